// >>> pwm_duty_and_ocr_timing_config.sv
`timescale 1ns/1ps
module pwm_duty_and_ocr_timing_config
  import pwm_ocr_pkg::*;
#(
  parameter int ON_TIME_US_0 = 88,
  parameter int ON_TIME_US_1 = 80,
  parameter int ON_TIME_US_2 = 72,
  parameter int ON_TIME_US_3 = 64,
  parameter int RETRY_HZ_0 = 1700,
  parameter int RETRY_HZ_1 = 2200,
  parameter int RETRY_HZ_2 = 3000,
  parameter int RETRY_HZ_3 = 4400,
  parameter int BLANK_US = 8,
  parameter int STEP_CYCLES = PWM_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_RETRY-1:0] overcurrent_in,
  input wire logic [NUM_RETRY-1:0] recovery_enable,
  output logic [NUM_CH-1:0] pwm_out,
  output logic [NUM_RETRY-1:0] retry_drive
);
  // ==========================================================
  // derived timing, on-times exact, periods rounded down
  localparam logic [TIMER_W-1:0] ON_CYC [4] = '{
    TIMER_W'(ON_TIME_US_0 * CLK_MHZ), TIMER_W'(ON_TIME_US_1 * CLK_MHZ),
    TIMER_W'(ON_TIME_US_2 * CLK_MHZ), TIMER_W'(ON_TIME_US_3 * CLK_MHZ)};
  localparam logic [TIMER_W-1:0] PERIOD_CYC [4] = '{
    TIMER_W'(SYS_CLK_HZ / RETRY_HZ_0), TIMER_W'(SYS_CLK_HZ / RETRY_HZ_1),
    TIMER_W'(SYS_CLK_HZ / RETRY_HZ_2), TIMER_W'(SYS_CLK_HZ / RETRY_HZ_3)};
  localparam logic [TIMER_W-1:0] BLANK_CYC = TIMER_W'(BLANK_US * CLK_MHZ);
  localparam int PRESC_W = $clog2(STEP_CYCLES + 1);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(STEP_CYCLES - 1);

  // ==========================================================
  // reset release
  logic rst_meta_reg, rst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // register file
  logic [DATA_W-1:0] retry_timing_reg, retry_timing_next;
  logic [DATA_W-1:0] duty_reg [NUM_PAIRS];
  logic [DATA_W-1:0] duty_next [NUM_PAIRS];
  logic [DATA_W-1:0] rate_select_reg, rate_select_next;
  logic [DATA_W-1:0] rdata_next;

  always_comb begin
    retry_timing_next = retry_timing_reg;
    rate_select_next = rate_select_reg;
    rdata_next = reg_rdata;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      duty_next[p] = duty_reg[p];
    end
    if (reg_wr_en) begin
      // masking drops reserved bits; the spare word has no storage
      if (reg_addr == ADDR_RETRY_TIMING) begin
        retry_timing_next = reg_wdata & RETRY_TIMING_MASK;
      end
      if (reg_addr == ADDR_RATE_SELECT) begin
        rate_select_next = reg_wdata & RATE_MASK;
      end
      for (int p = 0; p < NUM_PAIRS; p++) begin
        if (reg_addr == ADDR_DUTY_FIRST + ADDR_W'(p)) begin
          duty_next[p] = reg_wdata & DUTY_MASK;
        end
      end
    end
    if (reg_rd_en) begin
      rdata_next = ZERO_WORD;
      if (reg_addr == ADDR_RETRY_TIMING) begin
        rdata_next = retry_timing_reg;
      end
      if (reg_addr == ADDR_RATE_SELECT) begin
        rdata_next = rate_select_reg;
      end
      if (reg_addr >= ADDR_DUTY_FIRST && reg_addr <= ADDR_DUTY_LAST) begin
        rdata_next = duty_reg[3'(reg_addr - ADDR_DUTY_FIRST)];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_timing_reg <= RETRY_TIMING_RESET;
      rate_select_reg <= ZERO_WORD;
      reg_rdata <= ZERO_WORD;
      for (int p = 0; p < NUM_PAIRS; p++) begin
        duty_reg[p] <= ZERO_WORD;
      end
    end else begin
      retry_timing_reg <= retry_timing_next;
      rate_select_reg <= rate_select_next;
      reg_rdata <= rdata_next;
      for (int p = 0; p < NUM_PAIRS; p++) begin
        duty_reg[p] <= duty_next[p];
      end
    end
  end

  // ==========================================================
  // step prescaler, one tick per 1/1024 of the 200 Hz period
  logic [PRESC_W-1:0] presc_reg, presc_next;
  logic tick_reg, tick_next;

  always_comb begin
    tick_next = (presc_reg == PRESC_LAST);
    presc_next = tick_next ? '0 : presc_reg + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      tick_reg <= tick_next;
    end
  end

  // ==========================================================
  // pwm channels; channel k sits at index k-1
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_channel
      logic [DUTY_W:0] phase_reg, phase_next;
      logic [DUTY_W-1:0] position;
      logic [DUTY_W-1:0] duty_code;
      logic out_next;

      always_comb begin
        // even index is an odd-numbered channel, upper field of its pair
        if (ch % 2 == 0) begin
          duty_code = duty_reg[ch / 2][ODD_DUTY_LSB +: DUTY_W];
        end else begin
          duty_code = duty_reg[ch / 2][EVEN_DUTY_LSB +: DUTY_W];
        end
        phase_next = tick_reg ? phase_reg + 1'b1 : phase_reg;
        // 100 Hz steps on every second tick; a rate change may cut one period short
        if (rate_select_reg[ch]) begin
          position = phase_reg[DUTY_W-1:0];
        end else begin
          position = phase_reg[DUTY_W:1];
        end
        // strict compare: code 0 never high, top code low for one step
        out_next = (position < duty_code);
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          phase_reg <= '0;
          pwm_out[ch] <= 1'b0;
        end else begin
          phase_reg <= phase_next;
          pwm_out[ch] <= out_next;
        end
      end
    end
  endgenerate

  // ==========================================================
  // overcurrent sense synchroniser
  logic [NUM_RETRY-1:0] oc_meta_reg, oc_sync_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_meta_reg <= '0;
      oc_sync_reg <= '0;
    end else begin
      oc_meta_reg <= overcurrent_in;
      oc_sync_reg <= oc_meta_reg;
    end
  end

  // ==========================================================
  // retry timers: index 0 configurable, 1-2 mid outputs, 3-5 half bridges
  genvar oi;
  generate
    for (oi = 0; oi < NUM_RETRY; oi++) begin : g_retry
      localparam int ON_LSB = (oi == 0) ? CFG_ON_LSB :
                              (oi < FIRST_BRIDGE) ? MID_ON_LSB : BRIDGE_ON_LSB;
      localparam int RATE_LSB = (oi == 0) ? CFG_RATE_LSB :
                                (oi < FIRST_BRIDGE) ? MID_RATE_LSB : BRIDGE_RATE_LSB;
      logic [1:0] on_code;
      logic [1:0] rate_code;

      always_comb begin
        on_code = retry_timing_reg[ON_LSB +: 2];
        rate_code = retry_timing_reg[RATE_LSB +: 2];
      end

      retry_unit u_retry (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(recovery_enable[oi]),
        .overcurrent(oc_sync_reg[oi]),
        .on_cycles(ON_CYC[on_code]),
        .period_cycles(PERIOD_CYC[rate_code]),
        .blank_cycles(BLANK_CYC),
        .drive(retry_drive[oi])
      );
    end
  endgenerate
endmodule : pwm_duty_and_ocr_timing_config

// >>> pwm_ocr_pkg.sv
package pwm_ocr_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_RETRY_TIMING = 6'h30;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_FIRST = 6'h32;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_LAST = 6'h36;
  localparam logic [ADDR_W-1:0] ADDR_RATE_SELECT = 6'h37;
  localparam logic [ADDR_W-1:0] ADDR_SPARE = 6'h38;
  localparam logic [DATA_W-1:0] RETRY_TIMING_MASK = 24'h00_0FFF;
  localparam logic [DATA_W-1:0] RETRY_TIMING_RESET = 24'h00_0540;
  localparam logic [DATA_W-1:0] DUTY_MASK = 24'h3F_F3FF;
  localparam logic [DATA_W-1:0] RATE_MASK = 24'h00_03FF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 24'h00_0000;
  // ==========================================================
  // fields
  localparam int DUTY_W = 10;
  localparam int NUM_CH = 10;
  localparam int NUM_PAIRS = 5;
  localparam int ODD_DUTY_LSB = 12;
  localparam int EVEN_DUTY_LSB = 0;
  localparam int CFG_ON_LSB = 10;
  localparam int MID_ON_LSB = 8;
  localparam int BRIDGE_ON_LSB = 6;
  localparam int CFG_RATE_LSB = 4;
  localparam int MID_RATE_LSB = 2;
  localparam int BRIDGE_RATE_LSB = 0;
  localparam int NUM_RETRY = 6;
  localparam int FIRST_BRIDGE = 3;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int PWM_FAST_HZ = 200;
  localparam int PWM_STEPS = 1024;
  localparam int PWM_STEP_CYCLES = SYS_CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
  localparam int TIMER_W = 16;
  // ==========================================================
  // retry state
  typedef enum logic [2:0] {
    RETRY_IDLE = 3'b001,
    RETRY_ON = 3'b010,
    RETRY_OFF = 3'b100
  } retry_state_t;
endpackage : pwm_ocr_pkg

// >>> retry_unit.sv
`timescale 1ns/1ps
module retry_unit
  import pwm_ocr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic overcurrent,
  input wire logic [TIMER_W-1:0] on_cycles,
  input wire logic [TIMER_W-1:0] period_cycles,
  input wire logic [TIMER_W-1:0] blank_cycles,
  output logic drive
);
  retry_state_t state_reg, state_next;
  logic [TIMER_W-1:0] count_reg, count_next;
  logic fault_reg, fault_next;
  logic drive_next;

  // ==========================================================
  // retry sequencer
  always_comb begin
    state_next = state_reg;
    count_next = count_reg + 1'b1;
    fault_next = fault_reg;
    unique case (state_reg)
      RETRY_IDLE: begin
        count_next = '0;
        fault_next = 1'b0;
        if (enable && overcurrent) begin
          state_next = RETRY_OFF;
        end
      end
      RETRY_ON: begin
        // sensing is masked for the blanking part of the window
        if (overcurrent && count_reg >= blank_cycles) begin
          fault_next = 1'b1;
        end
        if (count_reg >= on_cycles - 1'b1) begin
          state_next = (fault_next) ? RETRY_OFF : RETRY_IDLE;
        end
      end
      RETRY_OFF: begin
        if (count_reg >= period_cycles - 1'b1) begin
          state_next = RETRY_ON;
          count_next = '0;
          fault_next = 1'b0;
        end
      end
      default: begin
        state_next = RETRY_IDLE;
      end
    endcase
    if (!enable) begin
      state_next = RETRY_IDLE;
      count_next = '0;
    end
    drive_next = (state_next == RETRY_ON);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RETRY_IDLE;
      count_reg <= '0;
      fault_reg <= 1'b0;
      drive <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      fault_reg <= fault_next;
      drive <= drive_next;
    end
  end
endmodule : retry_unit

// >>> pwm_ocr_asserts.sv
`timescale 1ns/1ps
module pwm_ocr_asserts
  import pwm_ocr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_RETRY-1:0] overcurrent_in,
  input wire logic [NUM_RETRY-1:0] recovery_enable,
  input wire logic [NUM_CH-1:0] pwm_out,
  input wire logic [NUM_RETRY-1:0] retry_drive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // register port
  // write then back-to-back read of the same place returns the masked data
  property wr_rd_p(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] m);
    reg_wr_en && !reg_rd_en && reg_addr == a ##1 reg_rd_en && !reg_wr_en && reg_addr == a
      |=> reg_rdata == ($past(reg_wdata, 2) & m);
  endproperty
  spare_zero_a: assert property (reg_rd_en && reg_addr == ADDR_SPARE |=> reg_rdata == ZERO_WORD)
    else $error("spare register read not zero");
  unmapped_zero_a: assert property (reg_rd_en && reg_addr == 6'h31 |=> reg_rdata == ZERO_WORD)
    else $error("unmapped read not zero");
  duty_resv_a: assert property (reg_rd_en && reg_addr >= ADDR_DUTY_FIRST
    && reg_addr <= ADDR_DUTY_LAST |=> (reg_rdata & ~DUTY_MASK) == ZERO_WORD)
    else $error("duty reserved bits set");
  rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  duty_wr_a: assert property (wr_rd_p(6'h33, DUTY_MASK))
    else $error("duty write readback wrong");
  rate_wr_a: assert property (wr_rd_p(ADDR_RATE_SELECT, RATE_MASK))
    else $error("rate write readback wrong");
  timing_wr_a: assert property (wr_rd_p(ADDR_RETRY_TIMING, RETRY_TIMING_MASK))
    else $error("retry timing readback wrong");
  // ==========================================================
  // retry outputs, then cover points
  retry_gate_a: assert property (1'b1 |=> (retry_drive & ~$past(recovery_enable)) == '0)
    else $error("retry drive without enable");
  cover property ($rose(retry_drive[0]));
  cover property ($rose(pwm_out[0]));
  cover property (reg_rd_en && reg_addr == ADDR_SPARE);
endmodule : pwm_ocr_asserts
bind pwm_duty_and_ocr_timing_config pwm_ocr_asserts u_pwm_ocr_asserts (.sys_clk, .rstn,
  .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .overcurrent_in,
  .recovery_enable, .pwm_out, .retry_drive);

// >>> tb_pwm_duty_and_ocr_timing_config.sv
`timescale 1ns/1ps
module tb_pwm_duty_and_ocr_timing_config;
  import pwm_ocr_pkg::*;
  typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;} row_t;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [NUM_RETRY-1:0] oc = '0;
  logic [NUM_RETRY-1:0] ren = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] q;
  logic [NUM_CH-1:0] pwm;
  logic [NUM_CH-1:0] prev;
  logic [NUM_RETRY-1:0] drv;
  int n_errors = 0;
  int checked = 0;
  int hi [3];
  int rises [2];
  int span;
  localparam int T_ON_US = 2;
  localparam int T_RETRY_HZ = 200_000;
  row_t rows [8] = '{'{6'h30, 24'hFF_FFFF, 24'h00_0FFF}, '{6'h32, 24'hFF_FFFF, 24'h3F_F3FF},
    '{6'h33, 24'h12_3456, 24'h12_3056}, '{6'h36, 24'h00_0001, 24'h00_0001},
    '{6'h37, 24'hFF_FFFF, 24'h00_03FF}, '{6'h38, 24'hFF_FFFF, 24'h00_0000},
    '{6'h31, 24'hFF_FFFF, 24'h00_0000}, '{6'h3F, 24'hFF_FFFF, 24'h00_0000}};
  always #10 sys_clk = ~sys_clk;
  // the reset-code on-time and rate, the blanking and the step are shortened; other codes keep real values
  pwm_duty_and_ocr_timing_config #(.ON_TIME_US_1(T_ON_US), .RETRY_HZ_0(T_RETRY_HZ),
    .BLANK_US(1), .STEP_CYCLES(2)) u_pwm_duty_and_ocr_timing_config (
    .sys_clk(sys_clk), .rstn(rstn), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .overcurrent_in(oc), .recovery_enable(ren),
    .pwm_out(pwm), .retry_drive(drv));
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // strobes stay up between back-to-back calls; idle drops them
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    rd_en = 1'b0;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    wr_en = 1'b0;
    rd_en = 1'b1;
    addr = a;
    @(posedge sys_clk);
    #1;
    q = rdata;
  endtask : rd
  task automatic idle;
    wr_en = 1'b0;
    rd_en = 1'b0;
  endtask : idle
  // cycles that retry drive 0 keeps the given level, capped
  task automatic measure(input logic level);
    span = 0;
    while (drv[0] === level && span < 600) begin
      @(posedge sys_clk);
      #1;
      span++;
    end
  endtask : measure
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #600_000;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    // ==========================================================
    // reset values, then row table of write and read back
    for (int a = 6'h30; a <= 6'h38; a++) begin
      rd(ADDR_W'(a));
      chk(q, a == 6'h30 ? RETRY_TIMING_RESET : ZERO_WORD);
    end
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      rd(rows[r].a);
      chk(q, rows[r].e);
    end
    // ==========================================================
    // ch1 512 at 200 Hz, ch2 off, ch3 full code at 100 Hz
    wr(6'h32, 24'h20_0000);
    wr(6'h33, 24'h3F_F000);
    wr(ADDR_RATE_SELECT, 24'h00_0001);
    idle();
    repeat (4096) @(posedge sys_clk);
    #1 prev = pwm;
    hi = '{0, 0, 0};
    rises = '{0, 0};
    repeat (4096) begin
      @(posedge sys_clk); #1;
      for (int c = 0; c < 3; c++) hi[c] += int'(pwm[c]);
      rises[0] += int'(pwm[0] && !prev[0]);
      rises[1] += int'(pwm[2] && !prev[2]);
      prev = pwm;
    end
    chk(DATA_W'(hi[0]), 24'h00_0800);
    chk(DATA_W'(hi[1]), 24'h00_0000);
    chk(DATA_W'(hi[2]), 24'h00_0FFC);
    chk(DATA_W'(rises[0]), 24'h00_0002);
    chk(DATA_W'(rises[1]), 24'h00_0001);
    // ==========================================================
    // retry on a held fault; only the enabled output retries
    wr(ADDR_RETRY_TIMING, RETRY_TIMING_RESET);
    idle();
    ren = 6'h01;
    oc = 6'h03;
    measure(1'b0);
    chk(DATA_W'(drv[0]), 24'h00_0001);
    measure(1'b1);
    chk(DATA_W'(span), DATA_W'(T_ON_US * CLK_MHZ));
    measure(1'b0);
    chk(DATA_W'(span), DATA_W'(SYS_CLK_HZ / T_RETRY_HZ - T_ON_US * CLK_MHZ));
    chk(DATA_W'(drv[1]), 24'h00_0000);
    // fault gone inside the window: this window ends and no retry follows
    oc = '0;
    span = 0;
    repeat (400) begin
      @(posedge sys_clk);
      #1;
      span += int'(drv[0]);
    end
    chk(DATA_W'(span), DATA_W'(T_ON_US * CLK_MHZ - 1));
    // dropping the enable cuts a running window at once
    oc = 6'h03;
    measure(1'b0);
    chk(DATA_W'(drv[0]), 24'h00_0001);
    ren = '0;
    @(posedge sys_clk);
    #1;
    chk(DATA_W'(drv), ZERO_WORD);
    // ==========================================================
    // second reset in mid-run brings back every reset value
    oc = '0;
    rstn = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(DATA_W'({pwm, drv}), ZERO_WORD);
    chk(rdata, ZERO_WORD);
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    rd(ADDR_RETRY_TIMING);
    chk(q, RETRY_TIMING_RESET);
    rd(ADDR_DUTY_FIRST);
    chk(q, ZERO_WORD);
    rd(ADDR_RATE_SELECT);
    chk(q, ZERO_WORD);
    idle();
    tally_and_finish();
  end
endmodule : tb_pwm_duty_and_ocr_timing_config
